//--- tcf_regs.vh
// Constants of the thermocouple channel data formatter: offsets, fields, resets, timing.
// Assumes a 250 MHz module clock and an APB bus with 32-bit data.
//
// Behaviour
// - Input word holds 12-bit value in low-byte bits 7:4 and high byte; bits 0,2,3 zero.
// - Low-byte bit 1 reports the channel line fault, 1 meaning fault; the formatter also sets it while sending the substitute value.
// - Channels two to four follow in bytes 3 to 8, same pair layout.
// - No output bytes under code 53; eight empty bytes under codes 33 and 37.
// - Lead break checking can be switched off; then no line faults are reported.
// - External cold junction: withhold values 0 to 250 steps of 160 ms after fault.
// - Internal cold junction: withholding steps are 240 ms, 0 to 250 steps.
// - Normal mode sends the live value; simulation mode sends the simulated value.
// - Current-value error mode sends the field value unchanged during errors.
// - Substitute error mode sends the substitute value marked as invalid data.
// - Last-valid error mode holds the last value valid before the fault.
// - Channel active state follows the module-wide active setting only.
// - Word-wise transfer sends the high byte of each word first.
// - A value is good only after the delay has run error-free after a fault; switching lead checking off clears a fault without it.
`ifndef TCF_REGS_VH
`define TCF_REGS_VH

`define TCF_CLK_MHZ 250
`define TCF_STEP_EXT_MS 160
`define TCF_STEP_INT_MS 240
// Step lengths in clock cycles: 160 ms and 240 ms at the 250 MHz module clock.
`define TCF_STEP_EXT_CYC 26'h262_5A00
`define TCF_STEP_INT_CYC 26'h393_8700
`define TCF_DELAY_MAX 8'h00_FA

`define TCF_OFS_CTRL 12'h0_00
`define TCF_OFS_SLOT 12'h0_04
`define TCF_OFS_CHMODE 12'h0_08
`define TCF_OFS_DELAY 12'h0_0C
`define TCF_OFS_VALUES 12'h0_10
`define TCF_OFS_STATUS 12'h0_14
`define TCF_OFS_IRQ_STAT 12'h0_18
`define TCF_OFS_IRQ_MASK 12'h0_1C
`define TCF_OFS_WORD01 12'h0_20
`define TCF_OFS_WORD23 12'h0_24

`define TCF_CTRL_ACTIVE 0
`define TCF_CTRL_LBC 1
`define TCF_CTRL_EXT_CJ 2
`define TCF_CTRL_RESET 3'h7

`define TCF_SLOT_STANDARD 8'h35
`define TCF_SLOT_QUAD2 8'h21
`define TCF_SLOT_OCTAL 8'h25
`define TCF_PAD_BYTES 5'h08
`define TCF_IN_BYTES 5'h08

`define TCF_EM_CURRENT 2'h0
`define TCF_EM_SUBST 2'h1
`define TCF_EM_LAST 2'h2

`endif

//--- tcf_formatter.v
// Thermocouple channel data formatter: four channel words, fault withholding,
// error substitution, simulation, process image byte stream and APB registers.
// Assumes conversions arrive as synchronous one-cycle strobes per channel.
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "tcf_regs.vh"

module tcf_formatter #(
    parameter [25:0] STEP_EXT_CYC = `TCF_STEP_EXT_CYC,
    parameter [25:0] STEP_INT_CYC = `TCF_STEP_INT_CYC
) (
    input wire MCLK,
    input wire RST_N,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    output reg IRQ,
    input wire CONV_VALID,
    input wire [1:0] CONV_CHAN,
    input wire [11:0] CONV_VALUE,
    input wire CONV_FAULT,
    input wire TX_START,
    output reg [7:0] TX_BYTE,
    output reg TX_VALID,
    output reg TX_INPUT,
    output reg TX_LAST,
    output reg [63:0] PROC_IMAGE
);

    // Stream states. Two suffice because the byte counter tells input bytes from padding
    // bytes; a wider state code would only add decode.
    localparam ST_IDLE = 1'b0;
    localparam ST_SEND = 1'b1;

    // Configuration, event, timer and stream registers.
    reg [2:0] ctrl;
    reg [7:0] slot_code;
    reg [15:0] chmode;
    reg [7:0] delay_cfg;
    reg [11:0] sim_value;
    reg [11:0] subst_value;
    reg [7:0] irq_stat;
    reg [7:0] irq_mask;
    reg [25:0] step_cnt;
    reg step_tick;
    reg state;
    reg [4:0] byte_idx;
    reg [4:0] byte_total;

    // Per-channel status and events gathered from the channel loop.
    wire [3:0] ch_fault;
    wire [3:0] ch_hold;
    wire [3:0] ch_seen;
    wire [3:0] ch_invalid;
    wire [3:0] ev_fault;
    wire [3:0] ev_good;
    wire [63:0] ch_word;

    // Control fields and the bus write strobe. The strobe needs PREADY so that a write
    // lands once, at the edge at which the master sees the answer.
    wire active = ctrl[`TCF_CTRL_ACTIVE];
    wire lbc_on = ctrl[`TCF_CTRL_LBC];
    wire ext_cj = ctrl[`TCF_CTRL_EXT_CJ];
    wire wr_en = PSEL & PENABLE & PREADY & PWRITE;
    wire [7:0] delay_eff = (delay_cfg > `TCF_DELAY_MAX) ? `TCF_DELAY_MAX : delay_cfg;
    wire [25:0] step_len = ext_cj ? STEP_EXT_CYC : STEP_INT_CYC;

    // Shared free-running step timer for withholding. It is not restarted by a change of
    // cold junction or by a fault clear, so the first step may be short; one timer for
    // all channels is traded for a release that can come up to one step early.
    always @(posedge MCLK) begin
        if (!RST_N) begin
            step_cnt <= 26'h000_0000;
            step_tick <= 1'b0;
        end else if (step_cnt >= step_len - 26'h000_0001) begin
            step_cnt <= 26'h000_0000;
            step_tick <= 1'b1;
        end else begin
            step_cnt <= step_cnt + 26'h000_0001;
            step_tick <= 1'b0;
        end
    end

    // Per-channel capture, fault withholding and value selection. A channel is in error
    // while its lead is faulty, while withholding runs and before its first data.
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_ch
            reg [11:0] live;
            reg [11:0] last_good;
            reg fault;
            reg seen;
            reg [7:0] hold;
            reg [15:0] word;
            reg inval;
            reg [11:0] next_val;
            reg next_inval;
            wire hit = CONV_VALID & ({30'h0000_0000, CONV_CHAN} == g); // Full-width compare.
            wire flt_in = CONV_FAULT & lbc_on & active;
            wire sim = chmode[4*g];
            wire [1:0] emode = chmode[4*g+2 -: 2];
            wire err = fault | (hold != 8'h00) | ~seen;
            wire clearing = hit & fault & ~flt_in;

            // Live capture; a delay is armed when a conversion clears a fault. A new fault during a
            // running delay wins and clears it, so a loose contact keeps the channel in
            // error until it has stayed healthy for the whole delay.
            always @(posedge MCLK) begin
                if (!RST_N) begin
                    live <= 12'h000;
                    fault <= 1'b0;
                    seen <= 1'b0;
                    hold <= 8'h00;
                end else begin
                    if (hit) begin
                        // A fault reading only counts while lead checking is on.
                        live <= CONV_VALUE;
                        fault <= flt_in;
                        seen <= 1'b1;
                    end else if (!lbc_on) begin
                        fault <= 1'b0;
                    end
                    // Withholding counter; it counts timer steps, not conversions.
                    if (hit & flt_in) begin
                        hold <= 8'h00;
                    end else if (clearing) begin
                        hold <= delay_eff;
                    end else if (step_tick && hold != 8'h00) begin
                        hold <= hold - 8'h01;
                    end
                end
            end

            // Choose the value to send according to operating and error mode. Simulation
            // takes priority over every error mode; an error code of three acts as current.
            always @* begin
                next_val = live;
                next_inval = 1'b0;
                if (sim) begin
                    next_val = sim_value;
                end else if (err) begin
                    if (emode == `TCF_EM_SUBST) begin
                        next_val = subst_value;
                        next_inval = 1'b1;
                    end else if (emode == `TCF_EM_LAST) begin
                        next_val = last_good;
                    end else begin
                        next_val = live;
                    end
                end
            end

            // Registered word; an inactive module sends all zeros. The last good value is
            // only refreshed while the channel is clean, so a fault never overwrites it.
            always @(posedge MCLK) begin
                if (!RST_N) begin
                    last_good <= 12'h000;
                    word <= 16'h0000;
                    inval <= 1'b0;
                end else begin
                    if (!err) begin
                        last_good <= live;
                    end
                    inval <= next_inval;
                    if (active) begin
                        word <= {next_val, 2'b00, fault | next_inval, 1'b0};
                    end else begin
                        word <= 16'h0000;
                    end
                end
            end

            // Status and event outputs of this channel.
            assign ch_fault[g] = fault;
            assign ch_hold[g] = hold != 8'h00;
            assign ch_seen[g] = seen;
            assign ch_invalid[g] = inval;
            assign ev_fault[g] = hit & flt_in & ~fault;
            assign ev_good[g] = step_tick & (hold == 8'h01) & ~fault;
            assign ch_word[16*g+15 -: 16] = word;
        end
    endgenerate

    // Process image in channel order, channel one in the lowest word. It lags the channel
    // words by one cycle so that the port comes straight from a flip-flop.
    always @(posedge MCLK) begin
        if (!RST_N) begin
            PROC_IMAGE <= 64'h0000_0000_0000_0000;
        end else begin
            PROC_IMAGE <= ch_word;
        end
    end

    // Byte stream: eight input bytes, high byte first, then the output padding of the slot code.
    // A start strobe while sending is ignored; the host must wait for the last byte.
    wire [15:0] cur_word = ch_word[16*byte_idx[2:1] +: 16];
    always @(posedge MCLK) begin
        if (!RST_N) begin
            state <= ST_IDLE;
            byte_idx <= 5'h00;
            byte_total <= `TCF_IN_BYTES;
            TX_BYTE <= 8'h00;
            TX_VALID <= 1'b0;
            TX_INPUT <= 1'b0;
            TX_LAST <= 1'b0;
        end else begin
            case (state)
                // Idle: valid, input and last flags low, and the slot code fixes the stream length at the start.
                ST_IDLE: begin
                    TX_VALID <= 1'b0;
                    TX_LAST <= 1'b0;
                    TX_INPUT <= 1'b0;
                    byte_idx <= 5'h00;
                    if (TX_START) begin
                        state <= ST_SEND;
                        if (slot_code == `TCF_SLOT_QUAD2 || slot_code == `TCF_SLOT_OCTAL) begin
                            byte_total <= `TCF_IN_BYTES + `TCF_PAD_BYTES;
                        end else begin
                            byte_total <= `TCF_IN_BYTES;
                        end
                    end
                end
                // Sending: one byte per cycle, input bytes first, then padding.
                default: begin
                    TX_VALID <= 1'b1;
                    TX_LAST <= (byte_idx == byte_total - 5'h01);
                    if (byte_idx < `TCF_IN_BYTES) begin
                        TX_INPUT <= 1'b1;
                        TX_BYTE <= byte_idx[0] ? cur_word[7:0] : cur_word[15:8];
                    end else begin
                        TX_INPUT <= 1'b0;
                        TX_BYTE <= 8'h00;
                    end
                    // The last byte returns the machine to idle in the same cycle.
                    if (byte_idx == byte_total - 5'h01) begin
                        state <= ST_IDLE;
                    end
                    byte_idx <= byte_idx + 5'h01;
                end
            endcase
        end
    end

    // Configuration registers written at the completing APB edge. Writes to read-only or
    // unmapped offsets fall through the chain and change nothing.
    always @(posedge MCLK) begin
        if (!RST_N) begin
            ctrl <= `TCF_CTRL_RESET;
            slot_code <= `TCF_SLOT_STANDARD;
            chmode <= 16'h0000;
            delay_cfg <= 8'h00;
            sim_value <= 12'h000;
            subst_value <= 12'h000;
            irq_mask <= 8'h00;
        end else if (wr_en) begin
            if (PADDR == `TCF_OFS_CTRL) begin
                ctrl <= PWDATA[2:0];
            end else if (PADDR == `TCF_OFS_SLOT) begin
                slot_code <= PWDATA[7:0];
            end else if (PADDR == `TCF_OFS_CHMODE) begin
                chmode <= PWDATA[15:0];
            end else if (PADDR == `TCF_OFS_DELAY) begin
                delay_cfg <= PWDATA[7:0];
            end else if (PADDR == `TCF_OFS_VALUES) begin
                // Simulated and substitute values share one word for all channels.
                sim_value <= PWDATA[11:0];
                subst_value <= PWDATA[27:16];
            end else if (PADDR == `TCF_OFS_IRQ_MASK) begin
                irq_mask <= PWDATA[7:0];
            end
        end
    end

    // Sticky events; a new event in the clearing cycle survives the write of one.
    // IRQ follows the next status value so an event raises it without an extra cycle.
    wire [7:0] irq_clr = (wr_en && PADDR == `TCF_OFS_IRQ_STAT) ? PWDATA[7:0] : 8'h00;
    wire [7:0] next_irq_stat = (irq_stat & ~irq_clr) | {ev_good, ev_fault};
    always @(posedge MCLK) begin
        if (!RST_N) begin
            irq_stat <= 8'h00;
            IRQ <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            IRQ <= |(next_irq_stat & irq_mask);
        end
    end

    // Read decode; one wait state so the data leaves a flip-flop. Any offset that is not
    // decoded answers with PSLVERR and zero data.
    reg [31:0] rd_mux;
    reg rd_err;
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        if (PADDR == `TCF_OFS_CTRL) begin
            rd_mux = {29'h0000_0000, ctrl};
        end else if (PADDR == `TCF_OFS_SLOT) begin
            rd_mux = {24'h00_0000, slot_code};
        end else if (PADDR == `TCF_OFS_CHMODE) begin
            rd_mux = {16'h0000, chmode};
        end else if (PADDR == `TCF_OFS_DELAY) begin
            rd_mux = {24'h00_0000, delay_cfg};
        end else if (PADDR == `TCF_OFS_VALUES) begin
            rd_mux = {4'h0, subst_value, 4'h0, sim_value};
        end else if (PADDR == `TCF_OFS_STATUS) begin
            // Status nibbles: invalid, seen, withholding and fault, channel one lowest.
            rd_mux = {16'h0000, ch_invalid, ch_seen, ch_hold, ch_fault};
        end else if (PADDR == `TCF_OFS_IRQ_STAT) begin
            rd_mux = {24'h00_0000, irq_stat};
        end else if (PADDR == `TCF_OFS_IRQ_MASK) begin
            rd_mux = {24'h00_0000, irq_mask};
        end else if (PADDR == `TCF_OFS_WORD01) begin
            rd_mux = ch_word[31:0];
        end else if (PADDR == `TCF_OFS_WORD23) begin
            rd_mux = ch_word[63:32];
        end else begin
            rd_err = 1'b1;
        end
    end

    // APB handshake: PREADY rises in the second access cycle for one cycle. A write
    // answers with zero read data, so PRDATA holds only until the next transfer.
    always @(posedge MCLK) begin
        if (!RST_N) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end else if (PSEL && PENABLE && !PREADY) begin
            PREADY <= 1'b1;
            PSLVERR <= rd_err;
            PRDATA <= PWRITE ? 32'h0000_0000 : rd_mux;
        end else begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end

endmodule // tcf_formatter
`default_nettype wire

//--- tcf_formatter_props.sv
// Checker of the formatter's bus and stream ports.
// Assumes binding to tcf_formatter, one clock and its reset.
`timescale 1ns/1ns
`default_nettype none
module tcf_formatter_props (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic IRQ,
    input wire logic TX_START,
    input wire logic [7:0] TX_BYTE,
    input wire logic TX_VALID,
    input wire logic TX_INPUT,
    input wire logic TX_LAST,
    input wire logic [63:0] PROC_IMAGE
);
    // All checks share the module clock and are quiet in reset.
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    chk_word_spare: assert property ((PROC_IMAGE & 64'h000D_000D_000D_000D) == 64'h0)
        else $error("spare word bits set");
    chk_pad_zero: assert property (TX_VALID && !TX_INPUT |-> TX_BYTE == 8'h00)
        else $error("padding byte not empty");
    chk_input_run: assert property ($rose(TX_VALID) |-> (TX_VALID && TX_INPUT) [*8])
        else $error("stream does not open with eight input bytes");
    chk_start_lat: assert property ($rose(TX_VALID) |-> $past(TX_START, 2))
        else $error("stream start latency wrong");
    chk_last_end: assert property (TX_LAST |-> TX_VALID ##1 !TX_VALID)
        else $error("stream runs past its last byte");
    chk_ready_take: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("bus answer late");
    chk_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    chk_err_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    cover property (TX_LAST && !TX_INPUT);
    cover property (PSLVERR);
    cover property ($rose(IRQ));
endmodule // tcf_formatter_props
bind tcf_formatter tcf_formatter_props chk_u (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ), .TX_START(TX_START),
    .TX_BYTE(TX_BYTE), .TX_VALID(TX_VALID), .TX_INPUT(TX_INPUT), .TX_LAST(TX_LAST),
    .PROC_IMAGE(PROC_IMAGE));
`default_nettype wire

//--- tcf_host_model.sv
// Station unit model: gathers one process image stream.
// Assumes the formatter's stream ports on the same clock.
`timescale 1ns/1ns
`default_nettype none
module tcf_host_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tx_start,
    input wire logic [7:0] tx_byte,
    input wire logic tx_valid,
    input wire logic tx_input,
    output logic [63:0] in_image,
    output logic [4:0] pad_count,
    output logic pad_dirty
);
    // Bytes shift in as they come, so channel one ends in the top word.
    always @(posedge clk) begin
        if (!rst_n || tx_start) begin
            in_image <= 64'h0;
            pad_count <= 5'h00;
            pad_dirty <= 1'b0;
        end else if (tx_valid && tx_input) begin
            in_image <= {in_image[55:0], tx_byte};
        end else if (tx_valid) begin
            pad_count <= pad_count + 5'h01;
            pad_dirty <= pad_dirty | (tx_byte != 8'h00);
        end
    end
endmodule // tcf_host_model
`default_nettype wire

//--- tcf_formatter_bench.sv
// Self-checking bench of the thermocouple channel data formatter.
// Assumes the formatter, its checker and the station model alongside.
`timescale 1ns/1ns
`default_nettype none
`include "tcf_regs.vh"
module tcf_formatter_bench;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic conv_valid = 1'b0;
    logic [1:0] conv_chan = 2'h0;
    logic [11:0] conv_value = 12'h000;
    logic conv_fault = 1'b0;
    logic tx_start = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq, err, tx_valid, tx_input, tx_last, pad_dirty;
    logic [7:0] tx_byte;
    logic [63:0] proc_image, in_image;
    logic [4:0] pad_count;
    logic [15:0] exp_w [0:3];
    logic [11:0] v, s, m;
    logic [7:0] slots [0:2] = '{`TCF_SLOT_STANDARD, `TCF_SLOT_QUAD2, `TCF_SLOT_OCTAL};
    integer seed = 32'hdc61_3ef0;
    int bad_count = 0;
    int checks = 0;

    // Short step counts of 20 and 30 cycles keep the withholding delays to about a hundred cycles.
    tcf_formatter #(.STEP_EXT_CYC(26'h14), .STEP_INT_CYC(26'h1E)) dut_u (.MCLK(mclk),
        .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq),
        .CONV_VALID(conv_valid), .CONV_CHAN(conv_chan), .CONV_VALUE(conv_value),
        .CONV_FAULT(conv_fault), .TX_START(tx_start), .TX_BYTE(tx_byte),
        .TX_VALID(tx_valid), .TX_INPUT(tx_input), .TX_LAST(tx_last),
        .PROC_IMAGE(proc_image));
    tcf_host_model host_u (.clk(mclk), .rst_n(rst_n), .tx_start(tx_start),
        .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_input(tx_input),
        .in_image(in_image), .pad_count(pad_count), .pad_dirty(pad_dirty));

    // Free-running 250 MHz clock.
    initial forever #2 mclk = ~mclk;

    function automatic logic [15:0] word(input logic [11:0] val, input logic flt);
        word = {val, 2'b00, flt, 1'b0};
    endfunction

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One bus transfer; the request is held until ready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic conv(input logic [1:0] c, input logic [11:0] val, input logic f);
        @(posedge mclk);
        conv_valid <= 1'b1;
        conv_chan <= c;
        conv_value <= val;
        conv_fault <= f;
        @(posedge mclk);
        conv_valid <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    task automatic stream();
        @(posedge mclk);
        tx_start <= 1'b1;
        @(posedge mclk);
        tx_start <= 1'b0;
        do @(posedge mclk); while (tx_last !== 1'b1);
        @(posedge mclk);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence: reset values, layout, stream, faults, modes, withholding.
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        apb(1'b0, `TCF_OFS_CTRL, 32'h0);
        check("ctrl", rd, 64'h7);
        apb(1'b0, `TCF_OFS_SLOT, 32'h0);
        check("slot", rd, 64'h35);
        apb(1'b0, 12'h040, 32'h0);
        check("unmapped", err, 64'h1);
        check("image", proc_image, 64'h0);
        // Before any data a substituting channel must show its substitute value.
        s = 12'($random(seed));
        apb(1'b1, `TCF_OFS_VALUES, {4'h0, s, 16'h0000});
        apb(1'b1, `TCF_OFS_CHMODE, 32'h2);
        repeat (3) @(posedge mclk);
        check("no data", proc_image[15:0], word(s, 1'b1));
        apb(1'b1, `TCF_OFS_CHMODE, 32'h0);
        for (int c = 0; c < 4; c++) begin
            v = 12'($random(seed));
            conv(2'(c), v, 1'b0);
            exp_w[c] = word(v, 1'b0);
        end
        check("image", proc_image, {exp_w[3], exp_w[2], exp_w[1], exp_w[0]});
        // Every slot layout keeps the two-slot module whole.
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `TCF_OFS_SLOT, {24'h0, slots[i]});
            stream();
            check("stream", in_image, {exp_w[0], exp_w[1], exp_w[2], exp_w[3]});
            check("pads", pad_count, (i == 0) ? 64'h0 : 64'h8);
            check("padval", pad_dirty, 64'h0);
        end
        v = 12'($random(seed));
        conv(2'h0, v, 1'b1);
        check("fault", proc_image[15:0], word(v, 1'b1));
        check("irq off", irq, 64'h0);
        apb(1'b1, `TCF_OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge mclk);
        check("irq", irq, 64'h1);
        apb(1'b1, `TCF_OFS_IRQ_STAT, 32'hFF);
        repeat (2) @(posedge mclk);
        check("irq clr", irq, 64'h0);
        apb(1'b1, `TCF_OFS_CTRL, 32'h5);
        conv(2'h0, v, 1'b1);
        check("no check", proc_image[15:0], word(v, 1'b0));
        apb(1'b1, `TCF_OFS_CTRL, 32'h7);
        s = 12'($random(seed));
        m = 12'($random(seed));
        apb(1'b1, `TCF_OFS_CHMODE, 32'h1420);
        apb(1'b1, `TCF_OFS_VALUES, {4'h0, s, 4'h0, m});
        apb(1'b1, `TCF_OFS_DELAY, 32'h4);
        conv(2'h1, v, 1'b1);
        check("subst", proc_image[31:16], word(s, 1'b1));
        conv(2'h2, v, 1'b0);
        conv(2'h2, m, 1'b1);
        check("last", proc_image[47:32], word(v, 1'b1));
        check("sim", proc_image[63:48], word(m, 1'b0));
        // Four steps: done within 80 cycles outside, not before 91 inside.
        for (int k = 0; k < 2; k++) begin
            conv(2'h1, v, 1'b1);
            conv(2'h1, v, 1'b0);
            check("held", proc_image[31:16], word(s, 1'b1));
            repeat (80) @(posedge mclk);
            conv(2'h1, v, 1'b0);
            check("hold", proc_image[31:16], word(k == 1 ? s : v, k == 1));
            apb(1'b1, `TCF_OFS_CTRL, 32'h3);
        end
        apb(1'b1, `TCF_OFS_CTRL, 32'h6);
        repeat (4) @(posedge mclk);
        check("inactive", proc_image, 64'h0);
        // A second reset in mid-run must bring the slot code back to standard.
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        apb(1'b0, `TCF_OFS_SLOT, 32'h0);
        check("slot reset", rd, 64'h35);
        close_out();
    end

    // Watchdog, far beyond the few hundred cycles the run needs.
    initial begin
        #60000;
        bad_count++;
        close_out();
    end
endmodule // tcf_formatter_bench
`default_nettype wire
